// ---- core/serial_port_clock_generator.sv ----
/*
 * Clock generator of a serial port: baud down-counter, transmit divider,
 * receiver recovery state counter and transfer clock pin handling.
 * Assumes an APB master on pclk and a peer on the transfer clock pin.
 */
// The implementer's own choices: the APB register port and the placing of the registers.
`include "clkgen_defines.svh"

module serial_port_clock_generator
    import clkgen_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Transfer clock pin
    input wire logic xfer_clk_in,
    output logic xfer_clk_out,
    output logic xfer_clk_oe,
    // Clock enables, mode and receiver state
    output logic tx_tick,
    output logic rx_tick,
    output logic tx_edge,
    output logic rx_edge,
    output logic [1:0] clk_mode,
    output logic [3:0] rx_state
);

    state_t s_r;
    state_t s_nxt;
    clk_mode_t mode;
    logic wr_en;
    logic rd_en;
    logic baud_tick;
    logic [3:0] tx_last;
    logic [3:0] rx_last;
    logic xck_rise;
    logic xck_fall;
    logic gen_rise;
    logic gen_fall;
    logic change_edge;
    logic sample_edge;

    // Mode from select, double speed and pin direction
    function automatic clk_mode_t decode_mode(input ctrl_t c);
        if (!c.sync_sel)
        begin
            return c.double_speed ? MODE_ASYNC_DOUBLE : MODE_ASYNC_NORMAL;
        end
        // Double speed ignored in sync modes
        return c.pin_dir ? MODE_SYNC_MASTER : MODE_SYNC_SLAVE;
    endfunction

    // Division factor minus one for a given mode
    function automatic logic [3:0] div_last(input clk_mode_t m);
        logic [4:0] d;
        d = `DIV_NORMAL;
        case (m)
            MODE_ASYNC_DOUBLE: d = `DIV_DOUBLE;
            MODE_SYNC_MASTER, MODE_SYNC_SLAVE: d = `DIV_SYNC;
            default: d = `DIV_NORMAL;
        endcase
        return 4'(d - 5'd1);
    endfunction

    assign mode = decode_mode(s_r.ctrl);
    assign wr_en = psel && penable && pwrite && s_r.pready;
    assign rd_en = psel && !penable && !pwrite;
    assign baud_tick = (s_r.count == 12'h000);
    assign tx_last = div_last(mode);
    assign rx_last = div_last(mode);
    // Edge detector compares the second synchroniser stage with its history stage
    assign xck_rise = s_r.xck_sync && !s_r.xck_prev;
    assign xck_fall = !s_r.xck_sync && s_r.xck_prev;
    assign gen_rise = baud_tick && !s_r.xck_out && (mode == MODE_SYNC_MASTER);
    assign gen_fall = baud_tick && s_r.xck_out && (mode == MODE_SYNC_MASTER);

    // Polarity picks change and sample edges of the transfer clock
    always_comb
    begin
        change_edge = 1'b0;
        sample_edge = 1'b0;
        if (mode == MODE_SYNC_SLAVE)
        begin
            change_edge = s_r.ctrl.polarity ? xck_fall : xck_rise;
            sample_edge = s_r.ctrl.polarity ? xck_rise : xck_fall;
        end
        else if (mode == MODE_SYNC_MASTER)
        begin
            change_edge = s_r.ctrl.polarity ? gen_fall : gen_rise;
            sample_edge = s_r.ctrl.polarity ? gen_rise : gen_fall;
        end
    end

    // Next state of the whole block
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.pready = 1'b0;
        // Two-cycle access: setup, then a one-cycle ready pulse
        if (psel && !penable)
        begin
            s_nxt.pready = 1'b1;
        end
        if (rd_en)
        begin
            case (paddr)
                `OFS_DIV_LOW: s_nxt.prdata = {24'h000000, s_r.divisor[7:0]};
                `OFS_DIV_HIGH: s_nxt.prdata = {28'h0000000, s_r.high_hold};
                `OFS_CTRL: s_nxt.prdata = {28'h0000000, s_r.ctrl};
                `OFS_STATUS: s_nxt.prdata = {24'h000000, 2'b00, mode,
                                             s_r.rx_state};
                default: s_nxt.prdata = 32'h00000000;
            endcase
        end

        // Down-counter; divisor spans 0..4095 in 12 bits
        if (baud_tick)
        begin
            s_nxt.divisor = {s_r.high_hold, s_r.divisor[7:0]};
            s_nxt.count = {s_r.high_hold, s_r.divisor[7:0]};
        end
        else
        begin
            s_nxt.count = s_r.count - 12'h001;
        end

        if (wr_en)
        begin
            case (paddr)
                `OFS_DIV_LOW:
                begin
                    // Low byte write commits held high nibble and reloads
                    s_nxt.divisor = {s_r.high_hold, pwdata[7:0]};
                    s_nxt.count = {s_r.high_hold, pwdata[7:0]};
                end
                `OFS_DIV_HIGH: s_nxt.high_hold = pwdata[3:0];
                `OFS_CTRL: s_nxt.ctrl = ctrl_t'(pwdata[`CTRL_W-1:0]);
                default: s_nxt.ctrl = s_r.ctrl;
            endcase
        end

        // Transmit divider and receiver state on the chosen source
        s_nxt.ticks = '0;
        if (mode == MODE_SYNC_SLAVE)
        begin
            // Edge seen two clocks after the pin moves
            s_nxt.ticks.tx_tick = xck_rise || xck_fall;
            s_nxt.ticks.rx_tick = xck_rise || xck_fall;
            s_nxt.tx_div = 4'h0;
            s_nxt.rx_state = 4'h0;
        end
        else if (baud_tick)
        begin
            s_nxt.ticks.rx_tick = 1'b1;
            s_nxt.rx_state = (s_r.rx_state >= rx_last) ? 4'h0
                           : s_r.rx_state + 4'h1;
            if (s_r.tx_div >= tx_last)
            begin
                s_nxt.tx_div = 4'h0;
                s_nxt.ticks.tx_tick = 1'b1;
            end
            else
            begin
                s_nxt.tx_div = s_r.tx_div + 4'h1;
            end
        end
        s_nxt.ticks.tx_edge = change_edge;
        s_nxt.ticks.rx_edge = sample_edge;

        // Pin synchroniser, two stages then history
        s_nxt.xck_meta = xfer_clk_in;
        s_nxt.xck_sync = s_r.xck_meta;
        s_nxt.xck_prev = s_r.xck_sync;

        // Master toggles pin each baud tick: period of 2 ticks
        if (mode == MODE_SYNC_MASTER)
        begin
            s_nxt.xck_oe = 1'b1;
            if (baud_tick)
            begin
                s_nxt.xck_out = !s_r.xck_out;
            end
        end
        else
        begin
            // Pin released outside master mode, idles at polarity level
            s_nxt.xck_oe = 1'b0;
            s_nxt.xck_out = s_r.ctrl.polarity;
        end
    end

    // Single state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_r <= '0;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flip-flops, except clk_mode decoded from ctrl and pslverr tied low
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = 1'b0;
    assign xfer_clk_out = s_r.xck_out;
    assign xfer_clk_oe = s_r.xck_oe;
    assign tx_tick = s_r.ticks.tx_tick;
    assign rx_tick = s_r.ticks.rx_tick;
    assign tx_edge = s_r.ticks.tx_edge;
    assign rx_edge = s_r.ticks.rx_edge;
    assign clk_mode = decode_mode(s_r.ctrl);
    assign rx_state = s_r.rx_state;

    // Checks
    AST_RELOAD: assert property (@(posedge pclk) disable iff (!presetn)
        baud_tick |=> s_r.count == s_r.divisor)
        else $error("counter did not reload divisor");
    AST_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
        (baud_tick && $past(baud_tick) && !$past(wr_en)) |->
        s_r.divisor == 12'h000)
        else $error("back to back ticks with nonzero divisor");
    AST_LOWWR: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == `OFS_DIV_LOW) |=>
        s_r.count == {$past(s_r.high_hold), $past(pwdata[7:0])})
        else $error("low byte write did not reload");
    AST_RXTICK: assert property (@(posedge pclk) disable iff (!presetn)
        (baud_tick && mode != MODE_SYNC_SLAVE) |=> rx_tick)
        else $error("receiver tick missing");
    AST_RXSTATE: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_ASYNC_DOUBLE && baud_tick && $stable(s_r.ctrl)) |=>
        s_r.rx_state <= 4'd7)
        else $error("double speed receiver beyond 8 states");
    AST_TXDIV: assert property (@(posedge pclk) disable iff (!presetn)
        tx_tick && mode == MODE_ASYNC_NORMAL && $stable(s_r.ctrl) |->
        $past(s_r.tx_div) == 4'd15)
        else $error("transmit divide by 16 broken");
    AST_PINOE: assert property (@(posedge pclk) disable iff (!presetn)
        !s_r.ctrl.sync_sel |=> !xfer_clk_oe)
        else $error("pin driven in async mode");
    AST_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SYNC_MASTER)[*2] |-> xfer_clk_oe)
        else $error("master not driving pin");
    AST_SLAVE: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SYNC_SLAVE && $rose(xfer_clk_in))[*1] ##1
        (mode == MODE_SYNC_SLAVE)[*2] |=> tx_tick)
        else $error("slave edge latency not two clocks");
    AST_SRCSLAVE: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == MODE_SYNC_SLAVE) |=> s_r.tx_div == 4'h0)
        else $error("baud source used in slave mode");

    COV_NORMAL: cover property (@(posedge pclk) tx_tick &&
        mode == MODE_ASYNC_NORMAL);
    COV_DOUBLE: cover property (@(posedge pclk) tx_tick &&
        mode == MODE_ASYNC_DOUBLE);
    COV_MASTER: cover property (@(posedge pclk) rx_edge &&
        mode == MODE_SYNC_MASTER);
    COV_SLAVE: cover property (@(posedge pclk) rx_edge &&
        mode == MODE_SYNC_SLAVE);

endmodule

// ---- shared/clkgen_defines.svh ----
/*
 * Constants of the serial port clock generator: register offsets, field
 * positions, reset values and division factors.
 * Assumes inclusion by bare name from the package and the core module.
 */
// Functional notes
// - Four clocking modes: normal async, double-speed async, sync master, sync slave.
// - Sync mode select clear means asynchronous, set means synchronous.
// - In sync mode, pin direction output means master, input means slave.
// - Transfer clock pin used only in synchronous mode.
// - Baud generator clocks both async modes and sync master mode.
// - Down-counter reloads divisor at zero and on low-byte write.
// - One baud tick per zero; tick rate is clock over divisor plus one.
// - Transmit bit clock is baud tick over 16, 8 or 2 by mode.
// - Receiver recovery machine runs on baud tick with 2, 8 or 16 states.
// - Bit rate is clock over 16, 8 or 2 times divisor plus one.
// - Divisor is 12 bits from high and low bytes, 0 to 4095.
// - Double speed affects async only; software keeps it clear in sync (the bench sets it in one sync master case).
// - Double speed receiver uses 8 samples per bit instead of 16.
// - External transfer clock is the source only in sync slave mode.
// - External clock passes a synchroniser then an edge detector.
// - Synchronise-and-detect path adds two system clock periods latency.
// - Sync master drives the generated clock out on the pin.
// - Sync data sampled on opposite edge to change; polarity bit selects.
`ifndef CLKGEN_DEFINES_SVH
`define CLKGEN_DEFINES_SVH

// Register byte offsets
`define OFS_DIV_LOW 12'h000
`define OFS_DIV_HIGH 12'h004
`define OFS_CTRL 12'h008
`define OFS_STATUS 12'h00c

// Control register fields
`define CTRL_SYNC_BIT 0
`define CTRL_DOUBLE_BIT 1
`define CTRL_DIR_BIT 2
`define CTRL_POL_BIT 3
`define CTRL_W 4

// Reset values
`define DIV_RESET 12'h000
`define CTRL_RESET 4'h0

// Division and state counts
`define DIV_NORMAL 5'd16
`define DIV_DOUBLE 5'd8
`define DIV_SYNC 5'd2

`endif

// ---- shared/clkgen_pkg.sv ----
/*
 * Types of the serial port clock generator.
 * Assumes the defines header sits alongside on the include path.
 */
`include "clkgen_defines.svh"

package clkgen_pkg;

    // Clocking modes
    typedef enum logic [1:0]
    {
        MODE_ASYNC_NORMAL,
        MODE_ASYNC_DOUBLE,
        MODE_SYNC_MASTER,
        MODE_SYNC_SLAVE
    } clk_mode_t;

    // Software control bits
    typedef struct packed
    {
        logic polarity;
        logic pin_dir;
        logic double_speed;
        logic sync_sel;
    } ctrl_t;

    // Clock enables handed to transmitter and receiver
    typedef struct packed
    {
        logic tx_tick;
        logic rx_tick;
        logic tx_edge;
        logic rx_edge;
    } ticks_t;

    // Whole module state
    typedef struct packed
    {
        logic [11:0] divisor;
        logic [3:0] high_hold;
        logic [11:0] count;
        ctrl_t ctrl;
        logic [3:0] tx_div;
        logic [3:0] rx_state;
        logic xck_meta;
        logic xck_sync;
        logic xck_prev;
        logic xck_out;
        logic xck_oe;
        ticks_t ticks;
        logic pready;
        logic [31:0] prdata;
    } state_t;

endpackage

// ---- tb/tb.sv ----
/*
 * Bench of the clock generator: APB master, tick gap monitor, peer.
 * Assumes the defines header on the include path.
 */
`include "clkgen_defines.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 5;
    logic pclk, presetn, psel, penable, pwrite, peer_run, peer_drv, pin;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic pready, pslverr, xfer_clk_out, xfer_clk_oe, tx_tick, rx_tick;
    logic [1:0] clk_mode;
    logic [3:0] rx_state;
    logic [31:0] rd_q[$];
    int rx_q[$], tx_q[$];
    int rx_cnt, tx_cnt, fail_count, cmp_count, n;
    bit rx_arm, tx_arm;
    logic tx_edge, rx_edge, pol_q, lvl;
    logic [1:0] mode_q;
    logic [2:0] ph;

    // Pin level from whichever side drives it
    assign pin = xfer_clk_oe ? xfer_clk_out : peer_drv;

    serial_port_clock_generator dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .xfer_clk_in(pin), .xfer_clk_out(xfer_clk_out),
        .xfer_clk_oe(xfer_clk_oe), .tx_tick(tx_tick), .rx_tick(rx_tick),
        .tx_edge(tx_edge), .rx_edge(rx_edge), .clk_mode(clk_mode),
        .rx_state(rx_state));

    xfer_peer #(.HALF(HALF)) peer (.pclk(pclk), .run(peer_run),
        .drv(peer_drv));

    initial
    begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    task end_sim;
        if (fail_count == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task give_up;
        fail_count++;
        end_sim();
    endtask

    task cmp32(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task cmp1(input string nm, input logic e, input logic g);
        cmp32(nm, {31'h0, e}, {31'h0, g});
    endtask

    // One APB transfer; a read notes its expected data first
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        if (!w)
            rd_q.push_back(d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= w ? d : 32'h0;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            give_up();
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Program a mode, then note the expected tick gaps
    task run_mode(input logic [3:0] ctl, input logic [11:0] dv,
                  input logic [1:0] md);
        int b;
        b = dv + 1;
        apb(1'b1, `OFS_DIV_HIGH, {28'h0, dv[11:8]});
        apb(1'b1, `OFS_DIV_LOW, {24'h0, dv[7:0]});
        apb(1'b1, `OFS_CTRL, {28'h0, ctl});
        peer_run <= 1'b1;
        pol_q <= ctl[3];
        mode_q <= md;
        cmp32("clk_mode", {30'h0, md}, {30'h0, clk_mode});
        // Pin enable is registered one clock after the mode
        @(posedge pclk);
        cmp1("xfer_clk_oe", md == 2'd2, xfer_clk_oe);
        apb(1'b0, `OFS_DIV_HIGH, {28'h0, dv[11:8]});
        apb(1'b0, `OFS_CTRL, {28'h0, ctl});
        rx_q.push_back(md == 2'd3 ? HALF : b);
        tx_q.push_back(md == 2'd3 ? HALF : (md == 2'd0 ? 16 * b :
            (md == 2'd1 ? 8 * b : 2 * b)));
        n = 0;
        while ((rx_q.size() > 0 || tx_q.size() > 0) && n < 20000)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 20000)
            give_up();
        peer_run <= 1'b0;
    endtask

    // Monitor: reads and tick gaps against the oldest note
    always @(posedge pclk)
    begin
        if (psel && penable && pready === 1'b1)
            cmp1("pslverr", 1'b0, pslverr);
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size())
            cmp32("prdata", rd_q.pop_front(), prdata);
        // Slave edges reflect the pin three samples back
        lvl = clk_mode[0] ? ph[2] : pin;
        if (clk_mode == mode_q && mode_q[1])
        begin
            if (rx_edge === 1'b1)
                cmp1("rx_edge_level", pol_q, lvl);
            if (tx_edge === 1'b1)
                cmp1("tx_edge_level", !pol_q, lvl);
        end
        ph = {ph[1:0], pin};
        rx_cnt++;
        tx_cnt++;
        if (rx_tick === 1'b1)
        begin
            if (rx_arm)
                cmp32("rx_gap", rx_q.pop_front(), rx_cnt);
            rx_arm = rx_q.size() > 0;
            rx_cnt = 0;
        end
        if (tx_tick === 1'b1)
        begin
            if (tx_arm)
                cmp32("tx_gap", tx_q.pop_front(), tx_cnt);
            tx_arm = tx_q.size() > 0;
            tx_cnt = 0;
        end
    end

    // Main sequence: every mode, random and boundary divisors
    initial
    begin
        logic [11:0] d;
        {psel, penable, pwrite, peer_run} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        {rx_cnt, tx_cnt, fail_count, cmp_count, n} = '0;
        {rx_arm, tx_arm} = 2'b00;
        pol_q = 1'b0;
        mode_q = 2'd0;
        ph = 3'h0;
        presetn = 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        void'($urandom(32'hca2d));
        apb(1'b0, 12'h010, 32'h0);
        repeat (2)
        begin
            d = 12'($urandom_range(6, 0));
            run_mode(4'h0, d, 2'd0);
            run_mode(4'h2, d, 2'd1);
            run_mode(4'h5, d, 2'd2);
            run_mode(4'h7, d, 2'd2);
            run_mode(4'h1, d, 2'd3);
            run_mode(4'h9, d, 2'd3);
        end
        run_mode(4'h0, 12'h000, 2'd0);
        run_mode(4'hd, 12'hfff, 2'd2);
        end_sim();
    end
endmodule

// ---- tb/xfer_peer.sv ----
/*
 * Far-side serial peer: drives the transfer clock pin when the port is
 * a slave. Assumes the bench resolves the pin from both drivers.
 */
module xfer_peer #(
    parameter int HALF = 5
)
(
    // Clock and control
    input wire logic pclk,
    input wire logic run,
    // Pin drive
    output logic drv
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt;

    initial
    begin
        drv = 1'b0;
        cnt = 0;
    end

    // Half period of at least 3 clocks keeps rate under a quarter
    always @(posedge pclk)
    begin
        if (run)
        begin
            cnt <= (cnt + 1 == HALF) ? 0 : cnt + 1;
            if (cnt + 1 == HALF)
                drv <= ~drv;
        end
    end
endmodule
